//--- inc/pcs_pkg.sv
`default_nettype none
package pcs_pkg;
  localparam int PCS_W         = 4;
  localparam int PCS_DEPTH     = 17;
  localparam int PCS_SP_W      = 5;
  localparam logic [4:0] OP_RESET      = 5'h00;
  localparam logic [4:0] OP_FETCH_PC   = 5'h01;
  localparam logic [4:0] OP_FETCH_R    = 5'h02;
  localparam logic [4:0] OP_FETCH_D    = 5'h03;
  localparam logic [4:0] OP_FETCH_RD   = 5'h04;
  localparam logic [4:0] OP_FETCH_PD   = 5'h05;
  localparam logic [4:0] OP_FETCH_PR   = 5'h06;
  localparam logic [4:0] OP_FETCH_SD   = 5'h07;
  localparam logic [4:0] OP_FETCH_PC_R = 5'h08;
  localparam logic [4:0] OP_FETCH_RD_R = 5'h09;
  localparam logic [4:0] OP_LOAD_R     = 5'h0A;
  localparam logic [4:0] OP_PUSH_PC    = 5'h0B;
  localparam logic [4:0] OP_PUSH_D     = 5'h0C;
  localparam logic [4:0] OP_POP_S      = 5'h0D;
  localparam logic [4:0] OP_POP_PC     = 5'h0E;
  localparam logic [4:0] OP_HOLD       = 5'h0F;
  localparam logic [4:0] OP_JMP_R      = 5'h10;
  localparam logic [4:0] OP_JMP_D      = 5'h11;
  localparam logic [4:0] OP_JMP_Z      = 5'h12;
  localparam logic [4:0] OP_JMP_RD     = 5'h13;
  localparam logic [4:0] OP_JMP_PD     = 5'h14;
  localparam logic [4:0] OP_JMP_PR     = 5'h15;
  localparam logic [4:0] OP_RET_S      = 5'h1C;
  localparam logic [4:0] OP_RET_SD     = 5'h1D;
  localparam logic [4:0] OP_COND_HOLD  = 5'h1E;
  localparam logic [4:0] OP_SUSPEND    = 5'h1F;
  localparam logic [4:0] SP_EMPTY      = 5'h00;
  localparam logic [4:0] SP_FULL       = 5'h11;
  // adder operand selects
  typedef enum logic [2:0] {
    PCS_SRC_ZERO = 3'h0,
    PCS_SRC_PC   = 3'h1,
    PCS_SRC_R    = 3'h2,
    PCS_SRC_D    = 3'h3,
    PCS_SRC_S    = 3'h4
  } pcs_src_t;
endpackage
`default_nettype wire

//--- inc/pcs_add_if.sv
`timescale 1ns/1ps
`default_nettype none
// operands and result of the cascadable address adder
interface pcs_add_if #(parameter int W = 4);
  logic [W-1:0] a;
  logic [W-1:0] b;
  logic         cin;
  logic [W-1:0] sum;
  logic         cout;
  modport user (output a, output b, output cin, input sum, input cout);
  modport adder (input a, input b, input cin, output sum, output cout);
endinterface
`default_nettype wire

//--- hw/pcs_adder.sv
`timescale 1ns/1ps
`default_nettype none
module pcs_adder #(
  parameter int W = 4
) (
  pcs_add_if.adder bus
);
  logic [W:0] full_sum;
  // full width sum keeps carry-out for slice cascading
  assign full_sum = {1'b0, bus.a} + {1'b0, bus.b} + {{W{1'b0}}, bus.cin}; // R22
  assign bus.sum  = full_sum[W-1:0];
  assign bus.cout = full_sum[W];
endmodule
`default_nettype wire

//--- hw/pcs_slice.sv
`timescale 1ns/1ps
`default_nettype none
// Function
// R1 - gate high keeps address outputs unchanged
// R2 - gate high freezes counter, pointer, stack
// R3 - opcode 0: zero out, counter=carry, clear pointer
// R4 - opcodes 1-7: fetch sources, counter advances
// R5 - opcode 8: counter copied into auxiliary register
// R6 - opcode 9: register plus direct into register
// R7 - opcode 10: direct loads register unconditionally
// R8 - opcodes 11,12: push counter or direct
// R9 - opcodes 13,14: pop, output top or counter
// R10 - opcode 15: hold everything, drive counter
// R11 - failed condition behaves as fetch counter
// R12 - opcodes 16-21: conditional jumps load counter
// R13 - opcodes 22-27: calls push old counter
// R14 - opcodes 28,29: returns decrement pointer
// R15 - opcode 30: conditional hold
// R16 - opcode 31: suspend floats address outputs
// R17 - adder carries may ripple between slices
// R18 - low load enable loads register from direct
// R19 - pointer saturates; writes blocked when full
// R20 - empty and full flags, active low
// R21 - state changes only on rising clock
// R22 - four bits wide with cascade carries
module pcs_slice
  import pcs_pkg::*;
#(
  parameter int W     = PCS_W,
  parameter int DEPTH = PCS_DEPTH
) (
  input  wire logic         ref_clk_i,
  input  wire logic         rst_i,
  input  wire logic [4:0]   opcode_bits_i,
  input  wire logic         instruction_gate_n_i,
  input  wire logic         cond_code_n_i,
  input  wire logic         aux_load_enable_n_i,
  input  wire logic         output_enable_n_i,
  input  wire logic         counter_incr_carry_in_i,
  input  wire logic         adder_carry_in_i,
  input  wire logic [W-1:0] direct_i,
  output logic [W-1:0]      addr_o,
  output logic              addr_oe_o,
  output logic              adder_carry_out_o,
  output logic              counter_incr_carry_out_o,
  output logic              empty_n_o,
  output logic              full_n_o
);
  logic [W-1:0]  program_counter_reg;
  logic [W-1:0]  aux_reg;
  logic [4:0]    stack_pointer_reg;
  logic [W-1:0]  stack_mem [0:DEPTH];
  logic [W-1:0]  stack_top;
  logic [4:0]    op_eff;
  logic          gate_on;
  pcs_src_t      sel_a;
  pcs_src_t      sel_b;
  logic          use_cn;
  logic [W-1:0]  op_a;
  logic [W-1:0]  op_b;
  logic [W-1:0]  incr_src;
  logic [W:0]    incr_full;
  logic [W-1:0]  pc_next;
  logic          pc_load;
  logic          do_push;
  logic          do_pop;
  logic          do_reset;
  logic          push_pc_src;
  logic          stack_full;
  logic          stack_empty;
  logic [4:0]    wr_ptr;

  pcs_add_if #(.W(W)) add_bus ();

  pcs_adder #(.W(W)) u_adder (
    .bus (add_bus)
  );

  // failed condition on a conditional opcode degrades to fetch counter
  assign op_eff  = (opcode_bits_i[4] && cond_code_n_i) ? OP_FETCH_PC : opcode_bits_i; // R11
  assign gate_on = !instruction_gate_n_i;
  assign stack_top = stack_mem[stack_pointer_reg];
  assign stack_full  = (stack_pointer_reg == SP_FULL);
  assign stack_empty = (stack_pointer_reg == SP_EMPTY);

  // operand selection; independent of the gate so address outputs never move with it
  always_comb begin // R1
    sel_a  = PCS_SRC_PC;
    sel_b  = PCS_SRC_ZERO;
    use_cn = 1'b0;
    case (op_eff)
      OP_RESET: sel_a = PCS_SRC_ZERO; // R3
      OP_FETCH_R, OP_JMP_R, 5'h16: sel_a = PCS_SRC_R; // R4
      OP_FETCH_D, OP_JMP_D, 5'h17: sel_a = PCS_SRC_D;
      OP_JMP_Z, 5'h18: sel_a = PCS_SRC_ZERO; // R12
      OP_FETCH_RD, OP_FETCH_RD_R, OP_JMP_RD, 5'h19: begin // R6
        sel_a  = PCS_SRC_R;
        sel_b  = PCS_SRC_D;
        use_cn = 1'b1;
      end
      OP_FETCH_PD, OP_JMP_PD, 5'h1A: begin
        sel_b  = PCS_SRC_D;
        use_cn = 1'b1;
      end
      OP_FETCH_PR, OP_JMP_PR, 5'h1B: begin // R13
        sel_b  = PCS_SRC_R;
        use_cn = 1'b1;
      end
      OP_FETCH_SD, OP_RET_SD: begin // R14
        sel_a  = PCS_SRC_S;
        sel_b  = PCS_SRC_D;
        use_cn = 1'b1;
      end
      OP_POP_S, OP_RET_S: sel_a = PCS_SRC_S; // R9
      default: sel_a = PCS_SRC_PC; // R10 R15
    endcase
  end

  function automatic logic [W-1:0] pick(input pcs_src_t s, input logic [W-1:0] pc,
                                        input logic [W-1:0] r, input logic [W-1:0] d,
                                        input logic [W-1:0] st);
    case (s)
      PCS_SRC_PC: pick = pc;
      PCS_SRC_R:  pick = r;
      PCS_SRC_D:  pick = d;
      PCS_SRC_S:  pick = st;
      default:    pick = '0;
    endcase
  endfunction

  assign op_a        = pick(sel_a, program_counter_reg, aux_reg, direct_i, stack_top);
  assign op_b        = pick(sel_b, program_counter_reg, aux_reg, direct_i, stack_top);
  assign add_bus.a   = op_a;
  assign add_bus.b   = op_b;
  assign add_bus.cin = use_cn & adder_carry_in_i;

  // incrementer steps the counter or the adder sum; its carry-out cascades
  // fetches step the old counter; reset, jumps, calls and returns step the target
  assign incr_src  = (op_eff[4] || op_eff == OP_RESET) ? add_bus.sum : program_counter_reg; // R4 R12
  assign incr_full = {1'b0, incr_src} + {{W{1'b0}}, counter_incr_carry_in_i}; // R22
  assign pc_next   = incr_full[W-1:0];
  assign counter_incr_carry_out_o = incr_full[W];
  assign adder_carry_out_o        = add_bus.cout; // R17

  // stack and counter control decode
  always_comb begin
    pc_load     = 1'b1;
    do_push     = 1'b0;
    do_pop      = 1'b0;
    do_reset    = 1'b0;
    push_pc_src = 1'b1;
    case (op_eff)
      OP_RESET: do_reset = 1'b1; // R3
      OP_PUSH_PC: do_push = 1'b1; // R8
      OP_PUSH_D: begin
        do_push     = 1'b1;
        push_pc_src = 1'b0;
      end
      OP_POP_S, OP_POP_PC, OP_RET_S, OP_RET_SD: do_pop = 1'b1; // R9 R14
      OP_HOLD, OP_COND_HOLD, OP_SUSPEND: pc_load = 1'b0; // R10 R15 R16
      5'h16, 5'h17, 5'h18, 5'h19, 5'h1A, 5'h1B: do_push = 1'b1; // R13
      default: pc_load = 1'b1;
    endcase
  end

  // program counter; reset opcode yields zero plus carry via zero select
  always_ff @(posedge ref_clk_i) begin // R21
    if (rst_i) begin
      program_counter_reg <= '0;
    end else if (gate_on && pc_load) begin // R2
      program_counter_reg <= pc_next; // R3 R4 R12
    end
  end

  // auxiliary register; opcode loads only while gate is low, load enable loads regardless of gate
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      aux_reg <= '0;
    end else if (gate_on && op_eff == OP_FETCH_PC_R) begin
      aux_reg <= program_counter_reg; // R5
    end else if (gate_on && op_eff == OP_FETCH_RD_R) begin
      aux_reg <= add_bus.sum; // R6
    end else if ((gate_on && op_eff == OP_LOAD_R) || !aux_load_enable_n_i) begin
      aux_reg <= direct_i; // R7 R18
    end
  end

  // stack pointer saturates at both ends
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      stack_pointer_reg <= SP_EMPTY;
    end else if (gate_on) begin // R2
      if (do_reset) begin
        stack_pointer_reg <= SP_EMPTY; // R3
      end else if (do_push && !stack_full) begin
        stack_pointer_reg <= stack_pointer_reg + 5'h01; // R8 R19
      end else if (do_pop && !stack_empty) begin
        stack_pointer_reg <= stack_pointer_reg - 5'h01; // R19
      end
    end
  end

  // word 0 is the empty slot, so pushes write 1..17
  assign wr_ptr = stack_pointer_reg + 5'h01;
  always_ff @(posedge ref_clk_i) begin
    if (!rst_i && gate_on && do_push && !stack_full) begin // R19
      stack_mem[wr_ptr] <= push_pc_src ? program_counter_reg : direct_i; // R8 R13
    end
  end

  // flags: full also during the push that fills
  assign empty_n_o = !stack_empty; // R20
  assign full_n_o  = !(stack_full || (stack_pointer_reg == SP_FULL - 5'h01 && do_push && gate_on)); // R20

  // suspend floats outputs when its condition passes
  assign addr_o    = add_bus.sum;
  assign addr_oe_o = !output_enable_n_i && (op_eff != OP_SUSPEND); // R16

  a_gate_hold: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    instruction_gate_n_i |=> $stable(program_counter_reg) && $stable(stack_pointer_reg)) // R2
    else $error("state changed while gate high");
  a_reset_op: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    (gate_on && opcode_bits_i == OP_RESET) |-> addr_o == '0 ##1 stack_pointer_reg == SP_EMPTY) // R3
    else $error("reset opcode wrong");
  a_fetch_pc: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    (gate_on && opcode_bits_i == OP_FETCH_PC) |-> addr_o == program_counter_reg
      ##1 program_counter_reg == $past(pc_next)) // R4
    else $error("fetch counter wrong");
  a_fail_cond: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    (opcode_bits_i[4] && cond_code_n_i) |-> addr_o == program_counter_reg && addr_oe_o == !output_enable_n_i) // R11
    else $error("failed condition not fetch");
  a_push_sp: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    (gate_on && opcode_bits_i == OP_PUSH_D && !stack_full) |=>
      stack_pointer_reg == $past(stack_pointer_reg) + 5'h01 && stack_top == $past(direct_i)) // R8
    else $error("push failed");
  a_sp_limit: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    stack_pointer_reg <= SP_FULL) // R19
    else $error("pointer overflow");
  a_pop_empty: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    (gate_on && do_pop && stack_empty) |=> stack_empty) // R19
    else $error("pop below empty");
  a_suspend_z: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    (opcode_bits_i == OP_SUSPEND && !cond_code_n_i) |-> !addr_oe_o) // R16
    else $error("suspend drives outputs");
  a_aux_copy: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    (gate_on && opcode_bits_i == OP_FETCH_PC_R) |=> aux_reg == $past(program_counter_reg)) // R5
    else $error("aux copy failed");
  a_hold_pc: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    (gate_on && opcode_bits_i == OP_HOLD) |=> $stable(program_counter_reg)) // R10
    else $error("hold moved counter");

  c_push_full: cover property (@(posedge ref_clk_i) stack_full);
  c_call: cover property (@(posedge ref_clk_i) gate_on && !cond_code_n_i && opcode_bits_i == 5'h16);
  c_return: cover property (@(posedge ref_clk_i) gate_on && !cond_code_n_i && opcode_bits_i == OP_RET_S);
  c_suspend: cover property (@(posedge ref_clk_i) !cond_code_n_i && opcode_bits_i == OP_SUSPEND);
endmodule
`default_nettype wire

//--- testbench/pcs_pipe_model.sv
`timescale 1ns/1ps
`default_nettype none
// pipeline register feeding the slice control pins
module pcs_pipe_model (
  input  wire logic        clk_i,
  input  wire logic [14:0] word_i,
  output logic [14:0]      ctl_o
);
  // starts with the gate high so the slice holds until the bench speaks
  logic [14:0] word_reg = 15'h0200;
  // new word launched on the rising edge, carry-in registered with the rest of the word
  always @(posedge clk_i) word_reg <= word_i;
  assign ctl_o = word_reg;
endmodule
`default_nettype wire

//--- testbench/test_program_control_slice.sv
`timescale 1ns/1ps
`default_nettype none
module test_program_control_slice;
  logic        ref_clk = 1'b0;
  logic        rst = 1'b1;
  logic [14:0] word = 15'h0200;
  logic [14:0] ctl;
  logic [3:0]  addr;
  logic        oe;
  logic        cout;
  logic        cio;
  logic        empty_n;
  logic        full_n;
  logic [15:0] lfsr = 16'h6336;
  int          pc = 0;
  int          r = 0;
  int          sp = 0;
  int          cyc = 0;
  int          stk[18];
  int          failures = 0;
  int          comparisons = 0;

  always #10 ref_clk = ~ref_clk;

  pcs_pipe_model pcs_pipe_model_inst (.clk_i(ref_clk), .word_i(word), .ctl_o(ctl));

  pcs_slice pcs_slice_inst (
    .ref_clk_i(ref_clk), .rst_i(rst), .opcode_bits_i(ctl[14:10]), .instruction_gate_n_i(ctl[9]),
    .cond_code_n_i(ctl[8]), .aux_load_enable_n_i(ctl[7]), .output_enable_n_i(ctl[6]),
    .counter_incr_carry_in_i(ctl[5]), .adder_carry_in_i(ctl[4]), .direct_i(ctl[3:0]),
    .addr_o(addr), .addr_oe_o(oe), .adder_carry_out_o(cout), .counter_incr_carry_out_o(cio),
    .empty_n_o(empty_n), .full_n_o(full_n));

  function automatic logic [15:0] lfsr_next(input logic [15:0] v);
    return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction

  task automatic chk_addr(input logic [3:0] exp, input logic [3:0] got);
    comparisons++;
    if (got !== exp) begin
      failures++;
      $display("FAIL t=%0t exp=%h got=%h", $time, exp, got);
    end
  endtask

  task automatic chk_flag(input logic exp, input logic got);
    comparisons++;
    if (got !== exp) begin
      failures++;
      $display("FAIL t=%0t exp=%h got=%h", $time, exp, got);
    end
  endtask

  task automatic print_verdict;
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  // reference model: inputs are settled at the falling edge, state moves one step per cycle
  always @(negedge ref_clk) begin : model
    int o, t, a, b, s, y, sum, npc, d, ci, cn, inc;
    bit srcsum, push, pop, oe_x;
    logic [15:0] v;
    o = ctl[14:10];
    d = ctl[3:0];
    ci = ctl[5];
    cn = ctl[4];
    s = (sp > 0) ? stk[sp] : 0;
    if (o >= 16 && ctl[8]) o = 1;
    t = (o >= 22 && o <= 27) ? o - 6 : o;
    srcsum = 1'b1;
    a = 0;
    b = 0;
    case (t)
      4, 9, 19: begin a = r; b = d; end
      5, 20: begin a = pc; b = d; end
      6, 21: begin a = pc; b = r; end
      7, 29: begin a = s; b = d; end
      default: srcsum = 1'b0;
    endcase
    sum = a + b + cn;
    case (t)
      0, 18: y = 0;
      2, 16: y = r;
      3, 17: y = d;
      13, 28: y = s;
      default: y = srcsum ? sum % 16 : pc;
    endcase
    push = (o == 11 || o == 12 || (o >= 22 && o <= 27));
    pop = (o == 13 || o == 14 || o == 28 || o == 29);
    oe_x = !ctl[6] && o != 31;
    if (rst) begin
      pc = 0;
      r = 0;
      sp = 0;
    end else begin
      chk_flag(oe_x, oe);
      if (oe_x) chk_addr(y[3:0], addr);
      chk_flag(sum[4], cout);
      chk_flag(sp != 0, empty_n);
      chk_flag(!(sp == 17 || (sp == 16 && push && !ctl[9])), full_n);
      // counter target worked out before any state moves; fetches step the old counter
      inc = ((o == 0 || o >= 16) ? y : pc) + ci;
      chk_flag(inc[4], cio);
      npc = (o == 15 || o >= 30) ? pc : inc % 16;
      if (!ctl[9] && o == 8) r = pc;
      else if (!ctl[9] && o == 9) r = sum % 16;
      else if ((!ctl[9] && o == 10) || !ctl[7]) r = d;
      if (!ctl[9]) begin
        if (push && sp < 17) begin
          sp++;
          stk[sp] = (o == 12) ? d : pc;
        end
        if (pop && sp > 0) sp--;
        if (o == 0) sp = 0;
        pc = npc % 16;
      end
    end
    // next control word; a stretch of pushes then pops drives the stack to both ends
    cyc++;
    lfsr = lfsr_next(lfsr_next(lfsr));
    v = lfsr;
    v[9] = &lfsr[9:7];
    v[6] = &lfsr[6:4];
    if (cyc >= 150 && cyc < 171) v[14:9] = {5'h0C, 1'b0};
    else if (cyc >= 171 && cyc < 192) v[14:9] = {(cyc % 2) ? 5'h0D : 5'h0E, 1'b0};
    // stack top is undefined on an empty stack (word 0 is never written), so those reads are steered away
    if (sp == 0 && (v[14:10] inside {5'h07, 5'h0D, 5'h1C, 5'h1D})) v[14:10] = 5'h0F;
    word = v;
  end

  initial begin
    repeat (10) @(posedge ref_clk);
    rst <= 1'b0;
    repeat (300) @(posedge ref_clk);
    rst <= 1'b1;
    repeat (2) @(posedge ref_clk);
    rst <= 1'b0;
    repeat (400) @(posedge ref_clk);
    print_verdict();
  end

  // watchdog well past the planned 712 cycles
  initial begin
    #(20 * 1000);
    failures++;
    print_verdict();
  end
endmodule
`default_nettype wire
